// File: assc_pkg.sv
package assc_pkg;
  // Character and frame widths
  localparam int DATA_W = 9;
  localparam int BYTE_W = 8;
  localparam int BAUD_W = 13;
  localparam int OVS = 16;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 13'h0001;
  // Receive buffer between the shifter and the processor side
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 32;
  // Mode encodings on the mode port
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_ASYNC8 = 2'h1;
  localparam logic [1:0] MODE_ASYNC9 = 2'h2;
  localparam logic [1:0] MODE_WAKE = 2'h3;
  // Bit counts per frame kind
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  // Rates at a 40 MHz CPU clock, for reference
  localparam int REF_CPU_MHZ = 40;
  localparam int REF_ASYNC_KBPS = 1250;
  localparam int REF_SYNC_KBPS = 5000;
  localparam int MIN_ASYNC_DIV = (REF_CPU_MHZ * 1000) / (REF_ASYNC_KBPS * OVS);
  localparam int MIN_SYNC_DIV = (REF_CPU_MHZ * 1000) / (REF_SYNC_KBPS * 2);
endpackage

// File: assc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module assc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  assign inReady = count_q != (AW+1)'(DEPTH);
  assign outValid = count_q != '0;
  assign outData = mem[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      count_q <= count_d;
    end
  end

  // Storage carries no reset; only the pointers and count define validity
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end
endmodule
`default_nettype wire

// File: assc_baud.sv
`timescale 1ns/1ps
`default_nettype none
module assc_baud
  import assc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Reload value, divide by reload+1
  input wire logic [BAUD_W-1:0] reload,
  input wire logic restart,
  // One-cycle tick per period
  output logic tick
);
  logic [BAUD_W-1:0] cnt_q, cnt_d;
  logic tick_d;

  always_comb begin
    tick_d = 1'b0;
    cnt_d = cnt_q - 1'b1;
    if (restart) begin
      cnt_d = reload;
    end else if (cnt_q == '0) begin
      cnt_d = reload;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q <= BAUD_RESET;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick <= tick_d;
    end
  end
endmodule
`default_nettype wire

// File: assc_top.sv
`timescale 1ns/1ps
`default_nettype none
module assc_top
  import assc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Configuration
  input wire logic [1:0] mode,
  input wire logic twoStop,
  input wire logic parityEn,
  input wire logic parityOdd,
  input wire logic frameChkEn,
  input wire logic overrunChkEn,
  input wire logic loopBack,
  input wire logic rxEnable,
  input wire logic [BAUD_W-1:0] baudReload,
  // Transmit data
  input wire logic txWrite,
  input wire logic [DATA_W-1:0] txData,
  output logic txBusy,
  // Receive data
  output logic rxValid,
  input wire logic rxRead,
  output logic [DATA_W-1:0] rxData,
  // Error flags and clears
  input wire logic clrParityErr,
  input wire logic clrFrameErr,
  input wire logic clrOverrunErr,
  output logic parityErr,
  output logic frameErr,
  output logic overrunErr,
  // Interrupt requests
  output logic txIrq,
  output logic txBufIrq,
  output logic rxIrq,
  output logic errIrq,
  // Serial pins; data pin is two-way in sync mode
  input wire logic rxdIn,
  output logic rxdOut,
  output logic rxdOe,
  output logic txdOut
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} assc_st_t;

  logic tick, isSync, isNine, ninth, frameDone;
  logic [3:0] nBits;
  logic fifoReady, fifoInValid;
  logic [FIFO_W-1:0] fifoInData;

  assign isSync = mode == MODE_SYNC;
  assign isNine = (mode == MODE_ASYNC9) || (mode == MODE_WAKE);
  // Parity only in 8-bit async; 9-bit and wake-up use the ninth bit as data
  assign ninth = (mode == MODE_ASYNC8) && parityEn;
  assign nBits = (isNine && !isSync) ? BITS_9 : BITS_8;

  assc_baud u_baud (
    .clk(clk),
    .rst_b(rst_b),
    .reload(baudReload),
    .restart(1'b0),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter; async uses 16 ticks per bit, sync two ticks per clock
  assc_st_t txSt_q, txSt_d;
  logic [DATA_W-1:0] txSh_q, txSh_d;
  logic [3:0] txCnt_q, txCnt_d, txPh_q, txPh_d;
  logic txPar_q, txPar_d, txd_q, txd_d, sclk_q, sclk_d, txStop2_q, txStop2_d;
  logic txIrq_d, txBufIrq_d, txBusy_d;
  logic txBitEnd;

  assign txBitEnd = tick && (isSync ? txPh_q[0] : (txPh_q == OVS_LAST));

  always_comb begin
    txSt_d = txSt_q;
    txSh_d = txSh_q;
    txCnt_d = txCnt_q;
    txPh_d = txPh_q;
    txPar_d = txPar_q;
    txd_d = txd_q;
    sclk_d = sclk_q;
    txStop2_d = txStop2_q;
    txIrq_d = 1'b0;
    txBufIrq_d = 1'b0;
    if (tick && txSt_q != ST_IDLE) begin
      txPh_d = txPh_q + 1'b1;
      if (isSync) begin
        sclk_d = ~txPh_q[0];
      end
    end
    case (txSt_q)
      ST_IDLE: begin
        txd_d = 1'b1;
        sclk_d = 1'b1;
        if (txWrite) begin
          txSh_d = txData;
          txPar_d = ^txData[BYTE_W-1:0] ^ parityOdd;
          txPh_d = '0;
          txCnt_d = '0;
          txStop2_d = twoStop;
          txBufIrq_d = 1'b1;
          txSt_d = isSync ? ST_DATA : ST_START;
          txd_d = isSync ? txData[0] : 1'b0;
          // Sync clock drops with the first bit so every rise finds settled data
          sclk_d = ~isSync;
        end
      end
      ST_START: begin
        if (txBitEnd) begin
          txd_d = txSh_q[0];
          txSt_d = ST_DATA;
        end
      end
      ST_DATA: begin
        if (txBitEnd) begin
          txSh_d = {1'b0, txSh_q[DATA_W-1:1]};
          txCnt_d = txCnt_q + 1'b1;
          txd_d = txSh_q[1];
          if (txCnt_q == nBits - 1'b1) begin
            if (isSync) begin
              txSt_d = ST_IDLE;
              txIrq_d = 1'b1;
              txd_d = 1'b1;
              // No last fall, so no ninth rising edge on the way back to idle
              sclk_d = 1'b1;
            end else if (ninth) begin
              txSt_d = ST_PAR;
              txd_d = txPar_q;
            end else begin
              txSt_d = ST_STOP;
              txd_d = 1'b1;
            end
          end
        end
      end
      ST_PAR: begin
        if (txBitEnd) begin
          txSt_d = ST_STOP;
          txd_d = 1'b1;
        end
      end
      ST_STOP: begin
        if (txBitEnd) begin
          if (txStop2_q) begin
            txStop2_d = 1'b0;
          end else begin
            txSt_d = ST_IDLE;
            txIrq_d = 1'b1;
          end
        end
      end
      default: txSt_d = ST_IDLE;
    endcase
    txBusy_d = txSt_d != ST_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txSt_q <= ST_IDLE;
      txSh_q <= '0;
      txCnt_q <= '0;
      txPh_q <= '0;
      txPar_q <= 1'b0;
      txd_q <= 1'b1;
      sclk_q <= 1'b1;
      txStop2_q <= 1'b0;
      txIrq <= 1'b0;
      txBufIrq <= 1'b0;
      txBusy <= 1'b0;
    end else begin
      txSt_q <= txSt_d;
      txSh_q <= txSh_d;
      txCnt_q <= txCnt_d;
      txPh_q <= txPh_d;
      txPar_q <= txPar_d;
      txd_q <= txd_d;
      sclk_q <= sclk_d;
      txStop2_q <= txStop2_d;
      txIrq <= txIrq_d;
      txBufIrq <= txBufIrq_d;
      txBusy <= txBusy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver; sync receive starts while rxEnable is set and nothing is sent, but samples only while a send advances txPh_q
  assc_st_t rxSt_q, rxSt_d;
  logic [DATA_W-1:0] rxSh_q, rxSh_d;
  logic [3:0] rxCnt_q, rxCnt_d, rxPh_q, rxPh_d;
  logic rxPar_q, rxPar_d, rxIn, rxSample;
  logic rxDone_d, parE_d, frmE_d;
  logic [DATA_W-1:0] rxWord_d;

  // Loop-back takes the internal line, the pin is ignored
  assign rxIn = loopBack ? txd_q : rxdIn;
  assign rxSample = tick && (isSync ? txPh_q[0] : (rxPh_q == OVS_MID));

  always_comb begin
    rxSt_d = rxSt_q;
    rxSh_d = rxSh_q;
    rxCnt_d = rxCnt_q;
    rxPh_d = tick ? rxPh_q + 1'b1 : rxPh_q;
    rxPar_d = rxPar_q;
    rxDone_d = 1'b0;
    parE_d = 1'b0;
    frmE_d = 1'b0;
    rxWord_d = rxSh_q;
    case (rxSt_q)
      ST_IDLE: begin
        rxCnt_d = '0;
        rxPh_d = '0;
        if (rxEnable && isSync && txSt_q == ST_IDLE && !txWrite) begin
          rxSt_d = ST_DATA;
        end else if (rxEnable && !isSync && !rxIn) begin
          rxSt_d = ST_START;
        end
      end
      ST_START: begin
        if (rxSample) begin
          rxSt_d = rxIn ? ST_IDLE : ST_DATA;
          rxPh_d = OVS_MID + 1'b1;
        end
      end
      ST_DATA: begin
        if (rxSample) begin
          rxSh_d = {rxIn, rxSh_q[DATA_W-1:1]};
          rxCnt_d = rxCnt_q + 1'b1;
          if (rxCnt_q == nBits - 1'b1) begin
            rxSt_d = isSync ? ST_IDLE : (ninth ? ST_PAR : ST_STOP);
            rxDone_d = isSync;
            rxWord_d = {1'b0, rxIn, rxSh_q[DATA_W-1:2]};
          end
        end
      end
      ST_PAR: begin
        if (rxSample) begin
          rxPar_d = rxIn;
          rxSt_d = ST_STOP;
        end
      end
      ST_STOP: begin
        if (rxSample) begin
          rxSt_d = ST_IDLE;
          rxDone_d = 1'b1;
          rxWord_d = isNine ? rxSh_q : {1'b0, rxSh_q[DATA_W-1:1]};
          frmE_d = frameChkEn && !rxIn;
          parE_d = ninth && (rxPar_q != (^rxWord_d[BYTE_W-1:0] ^ parityOdd));
        end
      end
      default: rxSt_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxSt_q <= ST_IDLE;
      rxSh_q <= '0;
      rxCnt_q <= '0;
      rxPh_q <= '0;
      rxPar_q <= 1'b0;
    end else begin
      rxSt_q <= rxSt_d;
      rxSh_q <= rxSh_d;
      rxCnt_q <= rxCnt_d;
      rxPh_q <= rxPh_d;
      rxPar_q <= rxPar_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer; a full buffer drops the character and counts as overrun
  logic fifoOutValid;
  logic [FIFO_W-1:0] fifoOutData;
  logic ovrEvent;
  assign fifoInValid = rxDone_d;
  assign fifoInData = rxWord_d;
  // Wake-up mode keeps only address characters (ninth bit set)
  assign ovrEvent = rxDone_d && !fifoReady && overrunChkEn;

  assc_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_rxfifo (
    .clk(clk),
    .rst_b(rst_b),
    .inValid(fifoInValid && (mode != MODE_WAKE || rxWord_d[BYTE_W])),
    .inReady(fifoReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(rxRead && rxValid),
    .outData(fifoOutData)
  );

  logic parErr_d, frmErr_d, ovrErr_d, errIrq_d;
  always_comb begin
    // Set wins over a clear in the same cycle
    parErr_d = parE_d | (parityErr & ~clrParityErr);
    frmErr_d = frmE_d | (frameErr & ~clrFrameErr);
    ovrErr_d = ovrEvent | (overrunErr & ~clrOverrunErr);
    errIrq_d = parE_d | frmE_d | ovrEvent;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      parityErr <= 1'b0;
      frameErr <= 1'b0;
      overrunErr <= 1'b0;
      errIrq <= 1'b0;
      rxIrq <= 1'b0;
      rxValid <= 1'b0;
      rxData <= '0;
      txdOut <= 1'b1;
      rxdOut <= 1'b1;
      rxdOe <= 1'b0;
    end else begin
      parityErr <= parErr_d;
      frameErr <= frmErr_d;
      overrunErr <= ovrErr_d;
      errIrq <= errIrq_d;
      rxIrq <= rxDone_d;
      rxValid <= fifoOutValid && !(rxRead && rxValid);
      rxData <= fifoOutData;
      // Sync: shift clock on the transmit pin, data on the two-way pin
      txdOut <= isSync ? sclk_d : txd_d;
      rxdOut <= txd_d;
      rxdOe <= isSync && txSt_d != ST_IDLE;
    end
  end
endmodule
`default_nettype wire

// File: assc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module assc_chk
  import assc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Configuration and requests
  input wire logic [1:0] mode,
  input wire logic parityEn,
  input wire logic overrunChkEn,
  input wire logic loopBack,
  input wire logic txWrite,
  input wire logic clrParityErr,
  input wire logic clrFrameErr,
  // Watched outputs
  input wire logic txBusy,
  input wire logic parityErr,
  input wire logic frameErr,
  input wire logic overrunErr,
  input wire logic txIrq,
  input wire logic errIrq,
  input wire logic rxdOe,
  input wire logic txdOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  chk_tx_taken: assert property (
    txWrite && !txBusy |=> txBusy) else $error("transmit request not taken");
  // Loop-back still drives the start bit on the pin, but it is left out here
  chk_start_low: assert property (
    txWrite && !txBusy && mode != MODE_SYNC && !loopBack |=> !txdOut)
    else $error("no start bit after transmit request");
  chk_oe_sync: assert property (
    rxdOe |-> mode == MODE_SYNC) else $error("data pin driven outside sync mode");
  chk_parity_hold: assert property (
    parityErr && !clrParityErr |=> parityErr) else $error("parity flag lost");
  chk_frame_clear: assert property (
    clrFrameErr |=> !frameErr || errIrq) else $error("framing flag not cleared");
  chk_parity_cause: assert property (
    $rose(parityErr) |-> $past(parityEn) && $past(mode) == MODE_ASYNC8)
    else $error("parity flag without parity mode");
  chk_err_request: assert property (
    $rose(frameErr) || $rose(parityErr) || $rose(overrunErr) |-> ##[0:1] errIrq)
    else $error("no error request on detection");
  chk_overrun_cause: assert property (
    $rose(overrunErr) |-> $past(overrunChkEn)) else $error("overrun flag while disabled");
  chk_txirq_pulse: assert property (
    txIrq |=> !txIrq) else $error("transmit request longer than a cycle");
endmodule
bind assc_top assc_chk i_chk (.*);
`default_nettype wire

// File: assc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module assc_partner #(
  parameter int BIT = 32
) (
  // Clock
  input wire logic clk,
  // Line from the channel and line to it
  input wire logic txd,
  output logic rxd,
  // Bits per character on txd
  input wire logic [3:0] nBits
);
  logic [8:0] got;
  int nGot = 0;
  initial rxd = 1'b1;
  ////////////////////////////////////////
  // A zero stop bit gives a broken frame on purpose
  task automatic send(input logic [8:0] d, input int n, input logic stopBit);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      rxd <= d[i];
      repeat (BIT) @(posedge clk);
    end
    rxd <= stopBit;
    repeat (BIT) @(posedge clk);
    rxd <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  ////////////////////////////////////////
  // Mid-bit sampling tolerates a few cycles of skew
  always begin
    @(negedge txd);
    got = 9'h000;
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < int'(nBits); i++) begin
      repeat (BIT) @(posedge clk);
      got[i] = txd;
    end
    repeat (BIT) @(posedge clk);
    nGot++;
  end
endmodule
`default_nettype wire

// File: test_assc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_assc_top import assc_pkg::*;;
  logic clk, rst_b, twoStop, parityEn, parityOdd, frameChkEn, overrunChkEn, loopBack;
  logic rxEnable, txWrite, rxRead, clrParityErr, clrFrameErr, clrOverrunErr;
  logic txBusy, rxValid, parityErr, frameErr, overrunErr, txIrq, txBufIrq, rxIrq, errIrq;
  logic rxdOut, rxdOe, txdOut;
  logic [1:0] mode;
  logic [3:0] nBits;
  logic [BAUD_W-1:0] baudReload;
  logic [DATA_W-1:0] txData, rxData;
  wire rxdIn;
  wire pRxd;
  int n_fail = 0;
  int num_checks = 0;
  int nTxIrq = 0;
  int nErrIrq = 0;
  int nSeen = 0;
  // Shared data pin: the channel wins while it drives
  assign rxdIn = rxdOe ? rxdOut : pRxd;
  assc_top i_dut (.*);
  assc_partner #(.BIT(32)) i_far (.clk(clk), .txd(txdOut), .rxd(pRxd), .nBits(nBits));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (txIrq === 1'b1) nTxIrq++;
    if (errIrq === 1'b1) nErrIrq++;
  end
  ////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rst(input logic [1:0] m, input logic par, input logic lb);
    rst_b = 1'b0;
    mode = m;
    parityEn = par;
    loopBack = lb;
    nBits = (m == MODE_ASYNC8 && !par) ? 4'h8 : 4'h9;
    cyc(2);
    rst_b = 1'b1;
  endtask
  task automatic idle();
    for (int k = 0; k < 3000 && txBusy !== 1'b0; k++) cyc(1);
    if (txBusy !== 1'b0) n_fail++;
  endtask
  task automatic xmit(input logic [8:0] d);
    idle();
    nSeen = i_far.nGot;
    txData = d;
    txWrite = 1'b1;
    cyc(1);
    txWrite = 1'b0;
    chk("txBusy", 9'h001, 9'(txBusy));
  endtask
  task automatic line(input logic [8:0] exp);
    for (int k = 0; k < 3000 && i_far.nGot == nSeen; k++) cyc(1);
    chk("line frame", exp, i_far.got);
  endtask
  task automatic pop(input logic [8:0] exp);
    for (int k = 0; k < 3000 && rxValid !== 1'b1; k++) cyc(1);
    chk("rxData", exp, rxData);
    rxRead = 1'b1;
    cyc(1);
    rxRead = 1'b0;
    cyc(2);
  endtask
  ////////////////////////////////////////
  task automatic t_tx();
    rst(MODE_ASYNC8, 1'b0, 1'b0);
    chk("idle pins", 9'h008, {5'h0, txdOut, rxdOe, txBusy, parityErr | frameErr});
    xmit(9'h0a5);
    line(9'h0a5);
    idle();
    parityOdd = 1'b1;
    twoStop = 1'b1;
    rst(MODE_ASYNC8, 1'b1, 1'b0);
    xmit(9'h007);
    line(9'h007);
    idle();
    cyc(4);
    chk("tx requests", 9'h002, 9'(nTxIrq));
    i_far.send(9'h107, 9, 1'b1);
    cyc(1);
    chk("parityErr", 9'h001, 9'(parityErr));
    chk("err requests", 9'h001, 9'(nErrIrq));
    cyc(50);
    chk("parity sticky", 9'h001, 9'(parityErr));
    clrParityErr = 1'b1;
    cyc(1);
    clrParityErr = 1'b0;
    cyc(1);
    chk("parity cleared", 9'h000, 9'(parityErr));
    parityOdd = 1'b0;
    twoStop = 1'b0;
  endtask
  task automatic t_rx();
    rst(MODE_ASYNC8, 1'b0, 1'b0);
    i_far.send(9'h055, 8, 1'b0);
    cyc(1);
    chk("frameErr", 9'h001, 9'(frameErr));
    rst(MODE_ASYNC9, 1'b0, 1'b0);
    fork
      i_far.send(9'h1a5, 9, 1'b1);
      begin
        xmit(9'h15a);
        line(9'h15a);
      end
    join
    pop(9'h1a5);
    rst(MODE_WAKE, 1'b0, 1'b0);
    i_far.send(9'h033, 9, 1'b1);
    i_far.send(9'h1c4, 9, 1'b1);
    cyc(1);
    pop(9'h1c4);
    rst(MODE_ASYNC8, 1'b0, 1'b1);
    xmit(9'h03c);
    pop(9'h03c);
  endtask
  // Far side keeps sending while nobody reads, so the buffer must refuse one
  task automatic t_fifo();
    rst(MODE_ASYNC8, 1'b0, 1'b0);
    for (int i = 0; i <= FIFO_D; i++) i_far.send(9'(i), 8, 1'b1);
    cyc(1);
    chk("overrunErr", 9'h001, 9'(overrunErr));
    for (int i = 0; i < FIFO_D; i++) pop(9'(i));
    chk("rxValid empty", 9'h000, 9'(rxValid));
    clrOverrunErr = 1'b1;
    cyc(1);
    clrOverrunErr = 1'b0;
    cyc(1);
    chk("overrun cleared", 9'h000, 9'(overrunErr));
  endtask
  task automatic t_sync();
    logic [7:0] v;
    logic oe;
    rst(MODE_SYNC, 1'b0, 1'b0);
    xmit(9'h0b4);
    for (int i = 0; i < 8; i++) begin
      @(posedge txdOut);
      v[i] = rxdOut;
      oe = rxdOe;
    end
    chk("sync byte", 9'h0b4, {1'b0, v});
    chk("sync drive", 9'h001, 9'(oe));
    cyc(1);
    idle();
    cyc(4);
    chk("sync release", 9'h000, 9'(rxdOe));
  endtask
  ////////////////////////////////////////
  initial begin
    {twoStop, parityOdd, txWrite, rxRead, clrParityErr, clrFrameErr, clrOverrunErr} = '0;
    {frameChkEn, overrunChkEn, rxEnable} = 3'h7;
    baudReload = 13'h0001;
    txData = 9'h000;
    t_tx();
    t_rx();
    t_fifo();
    t_sync();
    finish_test();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
